// ### logic/prsc_pin_ctrl.v
// Reset stretcher, strap capture, LED drivers and MII pin-state control
`timescale 1ns/1ns
`default_nettype none
`include "prsc_consts.vh"
module prsc_pin_ctrl #(
    parameter integer STRETCH_CYC = `PRSC_STRETCH_CYC,
    parameter integer BLINK_BITS  = 23
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        reset_n,
    input  wire        sw_reset,
    input  wire        soft_power_down,
    input  wire        mii_float_mode,
    input  wire        phy_addr_strap0,
    input  wire        phy_addr_strap1,
    input  wire [2:0]  indicator_strap_in,
    input  wire [5:0]  led_select,
    input  wire [2:0]  led_status,
    input  wire [3:0]  core_rxd,
    input  wire        core_rx_dv,
    input  wire        core_rx_er,
    input  wire        core_col,
    input  wire        core_crs,
    input  wire        core_tx_clk,
    input  wire        core_rx_clk,
    output reg         internal_reset_ff,
    output reg  [1:0]  phy_addr_ff,
    output reg  [2:0]  cfg_strap_ff,
    output reg         cfg_valid_ff,
    output reg  [2:0]  indicator_out_ff,
    output reg  [2:0]  indicator_oe_ff,
    output reg  [3:0]  rxd_ff,
    output reg         rx_dv_ff,
    output reg         rx_er_ff,
    output reg         col_ff,
    output reg         crs_ff,
    output reg         tx_clk_ff,
    output reg         rx_clk_ff,
    output reg         mii_out_oe_ff,
    output reg         mii_pulldown_ff,
    output reg         hardware_reset_state
);
    localparam [2:0] ST_HOLD = 3'b001;
    localparam [2:0] ST_STRETCH = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;
    localparam [31:0] LAST = STRETCH_CYC - 1;

    reg [2:0]            state_ff;
    reg [2:0]            nxt_state;
    reg [31:0]           cnt_ff;
    reg [BLINK_BITS-1:0] blink_ff;
    wire                 req = ~reset_n | sw_reset;
    wire                 done = (cnt_ff == LAST);

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HOLD: begin
                if (!req)
                    nxt_state = ST_STRETCH;
            end
            ST_STRETCH: begin
                if (req)
                    nxt_state = ST_HOLD;
                else if (done)
                    nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (req)
                    nxt_state = ST_HOLD;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= ST_HOLD;
            cnt_ff <= 32'h0;
            blink_ff <= {BLINK_BITS{1'b0}};
        end else begin
            state_ff <= nxt_state;
            blink_ff <= blink_ff + 1'b1;
            // Restart the stretch whenever the request reappears
            if (state_ff != ST_STRETCH || req)
                cnt_ff <= 32'h0;
            else
                cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // Straps sampled while pins are still inputs, the cycle before release
    wire capture = (state_ff == ST_STRETCH) && !req && done;
    wire running = (nxt_state == ST_RUN);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            internal_reset_ff <= 1'b1;
            hardware_reset_state <= 1'b1;
            phy_addr_ff <= 2'h0;
            cfg_strap_ff <= `PRSC_CFG_RST;
            cfg_valid_ff <= 1'b0;
        end else begin
            internal_reset_ff <= ~running;
            hardware_reset_state <= ~running;
            if (capture) begin
                phy_addr_ff <= {phy_addr_strap1, phy_addr_strap0};
                cfg_strap_ff <= indicator_strap_in;
                cfg_valid_ff <= 1'b1;
            end else if (nxt_state == ST_HOLD) begin
                cfg_valid_ff <= 1'b0;
            end
        end
    end

    wire [2:0]           led_lit;
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_led
            wire [1:0] sel = led_select[2*i+1:2*i];
            reg        lit;
            always @* begin
                lit = 1'b0;
                case (sel)
                    `PRSC_SEL_OFF:    lit = 1'b0;
                    `PRSC_SEL_ON:     lit = 1'b1;
                    `PRSC_SEL_STATUS: lit = led_status[i];
                    `PRSC_SEL_BLINK:
                        lit = led_status[i] & blink_ff[BLINK_BITS-1];
                    default:          lit = 1'b0;
                endcase
            end
            assign led_lit[i] = lit;
        end
    endgenerate

    // One register per vector keeps a single driver for each output
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            indicator_out_ff <= 3'h0;
            indicator_oe_ff <= 3'h0;
        end else begin
            // Pins stay inputs until the straps are taken
            indicator_oe_ff <= {3{running}};
            indicator_out_ff <= {3{running}} & led_lit;
        end
    end

    // Hardware reset outranks float mode, which outranks power-down
    localparam [3:0] PM_RESET  = 4'b0001;
    localparam [3:0] PM_FLOAT  = 4'b0010;
    localparam [3:0] PM_DOWN   = 4'b0100;
    localparam [3:0] PM_NORMAL = 4'b1000;

    reg [3:0]            pin_mode;

    always @* begin
        if (!running) begin
            pin_mode = PM_RESET;
        end else if (mii_float_mode) begin
            pin_mode = PM_FLOAT;
        end else if (soft_power_down) begin
            pin_mode = PM_DOWN;
        end else begin
            pin_mode = PM_NORMAL;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rxd_ff <= 4'h0;
            rx_dv_ff <= 1'b0;
            rx_er_ff <= 1'b0;
            col_ff <= 1'b0;
            crs_ff <= 1'b0;
            tx_clk_ff <= 1'b1;
            rx_clk_ff <= 1'b1;
            mii_out_oe_ff <= 1'b1;
            mii_pulldown_ff <= 1'b1;
        end else begin
            case (pin_mode)
                PM_RESET: begin
                    rxd_ff <= 4'h0;
                    rx_dv_ff <= 1'b0;
                    rx_er_ff <= 1'b0;
                    col_ff <= 1'b0;
                    crs_ff <= 1'b0;
                    tx_clk_ff <= 1'b1;
                    rx_clk_ff <= 1'b1;
                    mii_out_oe_ff <= 1'b1;
                    mii_pulldown_ff <= 1'b1;
                end
                PM_FLOAT: begin
                    rxd_ff <= 4'h0;
                    rx_dv_ff <= 1'b0;
                    rx_er_ff <= 1'b0;
                    col_ff <= 1'b0;
                    crs_ff <= 1'b0;
                    tx_clk_ff <= 1'b0;
                    rx_clk_ff <= 1'b0;
                    mii_out_oe_ff <= 1'b0;
                    mii_pulldown_ff <= 1'b1;
                end
                PM_DOWN: begin
                    rxd_ff <= 4'h0;
                    rx_dv_ff <= 1'b0;
                    rx_er_ff <= 1'b0;
                    col_ff <= 1'b0;
                    crs_ff <= 1'b0;
                    tx_clk_ff <= core_tx_clk;
                    rx_clk_ff <= core_rx_clk;
                    mii_out_oe_ff <= 1'b1;
                    mii_pulldown_ff <= 1'b1;
                end
                PM_NORMAL: begin
                    rxd_ff <= core_rxd;
                    rx_dv_ff <= core_rx_dv;
                    rx_er_ff <= core_rx_er;
                    col_ff <= core_col;
                    crs_ff <= core_crs;
                    tx_clk_ff <= core_tx_clk;
                    rx_clk_ff <= core_rx_clk;
                    mii_out_oe_ff <= 1'b1;
                    mii_pulldown_ff <= 1'b0;
                end
                // Unknown code falls back to the safe reset levels
                default: begin
                    rxd_ff <= 4'h0;
                    rx_dv_ff <= 1'b0;
                    rx_er_ff <= 1'b0;
                    col_ff <= 1'b0;
                    crs_ff <= 1'b0;
                    tx_clk_ff <= 1'b1;
                    rx_clk_ff <= 1'b1;
                    mii_out_oe_ff <= 1'b1;
                    mii_pulldown_ff <= 1'b1;
                end
            endcase
        end
    end
endmodule // prsc_pin_ctrl
`default_nettype wire

// ### logic/prsc_consts.vh
// Constants for the transceiver reset and pin-state controller
// Functional notes
// - Internal reset active while external reset low or software reset bit set.
// - Reset cycle stretched a nominal 258 us after the request goes away.
// - Management address taken from the two address strap pins.
// - Each of three indicator pins drives one LED status chosen per pin.
// - The three indicator pins double as configuration strap inputs.
// - Hardware reset: receive outputs low, clocks high, weak pull-downs on TXD/TX_EN.
// - Soft power-down: receive outputs low, clocks running, pull-downs on inputs.
// - Float mode: all MII outputs high impedance with pull-downs, inputs pulled down.
`ifndef PRSC_CONSTS_VH
`define PRSC_CONSTS_VH
`define PRSC_CLK_MHZ       250
`define PRSC_STRETCH_US    258
`define PRSC_STRETCH_CYC   (`PRSC_STRETCH_US * `PRSC_CLK_MHZ)
`define PRSC_SEL_W         2
`define PRSC_SEL_OFF       2'h0
`define PRSC_SEL_ON        2'h1
`define PRSC_SEL_STATUS    2'h2
`define PRSC_SEL_BLINK     2'h3
`define PRSC_CFG_RST       3'h0
`define PRSC_LED_SEL_RST   6'h00
`endif

// ### tb/prsc_assertions.sv
// Checker for reset stretch, strap capture and MII pin states
`timescale 1ns/1ns
`default_nettype none
module prsc_assertions #(parameter integer STRETCH_CYC = 8) (
    input wire       clock, rst, reset_n, sw_reset, soft_power_down,
    input wire       mii_float_mode, phy_addr_strap0, phy_addr_strap1,
    input wire [2:0] indicator_strap_in, cfg_strap_ff, indicator_oe_ff,
    input wire [3:0] rxd_ff, core_rxd,
    input wire [1:0] phy_addr_ff,
    input wire       internal_reset_ff, cfg_valid_ff, rx_dv_ff, tx_clk_ff,
    input wire       core_tx_clk, mii_out_oe_ff, mii_pulldown_ff,
    input wire       hardware_reset_state, rx_er_ff, col_ff, crs_ff,
    input wire       rx_clk_ff, core_rx_clk, core_rx_dv
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire req = !reset_n || sw_reset;
    int  quiet;
    // Saturates so a long quiet run cannot wrap
    always @(posedge clock or posedge rst)
        if (rst) quiet <= 0;
        else quiet <= req ? 0 : quiet + (quiet < 99);
    sequence fell_s; $fell(internal_reset_ff); endsequence
    sequence run_s; !internal_reset_ff; endsequence
    req_raise_a: assert property (req |=> internal_reset_ff)
        else $error("no reset");
    stretch_lo_a: assert property (quiet <= STRETCH_CYC |-> internal_reset_ff)
        else $error("short");
    stretch_hi_a: assert property (quiet == STRETCH_CYC + 1 |-> run_s)
        else $error("long");
    mirror_a: assert property (hardware_reset_state == internal_reset_ff)
        else $error("mirror");
    pass_a: assert property (run_s ##0 !$past(mii_float_mode)
        ##0 !$past(soft_power_down) |-> rxd_ff == $past(core_rxd)
        && rx_dv_ff == $past(core_rx_dv) && mii_out_oe_ff
        && !mii_pulldown_ff) else $error("normal");
    capture_a: assert property (fell_s |-> cfg_valid_ff &&
        cfg_strap_ff == $past(indicator_strap_in) &&
        phy_addr_ff == {$past(phy_addr_strap1), $past(phy_addr_strap0)})
        else $error("strap");
    hold_a: assert property (cfg_valid_ff && $past(cfg_valid_ff) |-> $stable(cfg_strap_ff))
        else $error("strap moved");
    hw_pins_a: assert property (internal_reset_ff && $past(internal_reset_ff)
        |-> rxd_ff == 4'h0 && !rx_dv_ff && tx_clk_ff && mii_out_oe_ff
        && !rx_er_ff && !col_ff && !crs_ff && rx_clk_ff
        && mii_pulldown_ff && indicator_oe_ff == 3'h0) else $error("hw pins");
    float_a: assert property (run_s ##0 $past(mii_float_mode)
        |-> !mii_out_oe_ff && mii_pulldown_ff) else $error("float");
    pwrdn_a: assert property (run_s ##0 $past(soft_power_down)
        ##0 !$past(mii_float_mode)
        |-> mii_out_oe_ff && mii_pulldown_ff && rxd_ff == 4'h0 && !rx_dv_ff
        && !rx_er_ff && !col_ff && !crs_ff
        && rx_clk_ff == $past(core_rx_clk)
        && tx_clk_ff == $past(core_tx_clk)) else $error("power down");
endmodule // prsc_assertions
bind prsc_pin_ctrl prsc_assertions #(.STRETCH_CYC(STRETCH_CYC)) i_chk (.*);
`default_nettype wire

// ### tb/prsc_mac_model.sv
// MAC-side view of the receive data pins
`timescale 1ns/1ns
`default_nettype none
module prsc_mac_model (
    input wire [3:0]   rxd_ff,
    input wire         mii_out_oe_ff, mii_pulldown_ff,
    output logic [3:0] rxd_seen
);
    // Unpulled float shows the inverse so stale data never matches
    assign rxd_seen = mii_out_oe_ff ? rxd_ff
        : (mii_pulldown_ff ? 4'h0 : ~rxd_ff);
endmodule // prsc_mac_model
`default_nettype wire

// ### tb/phy_reset_and_pin_state_control_bench.sv
// Bench: random straps, reset requests, MII modes and LED selects
`timescale 1ns/1ns
`default_nettype none
module phy_reset_and_pin_state_control_bench;
    localparam integer N = 8;
    logic clock = 0, rst = 1, reset_n = 0, sw_reset = 0, core_tx_clk = 0;
    logic soft_power_down = 0, mii_float_mode = 0, was = 1;
    logic phy_addr_strap0 = 0, phy_addr_strap1 = 0, core_rx_dv = 0;
    logic core_rx_er = 0, core_col = 0, core_crs = 0, core_rx_clk = 0;
    logic [2:0] indicator_strap_in = 0, led_status = 0;
    logic [5:0] led_select = 0;
    logic [4:0] s, q[$];
    logic [3:0] core_rxd = 0, rxd_seen;
    wire [3:0] rxd_ff;
    wire [2:0] cfg_strap_ff, indicator_out_ff, indicator_oe_ff;
    wire [1:0] phy_addr_ff;
    wire internal_reset_ff, cfg_valid_ff, rx_dv_ff, rx_er_ff, col_ff, crs_ff;
    wire tx_clk_ff, rx_clk_ff, mii_out_oe_ff, mii_pulldown_ff;
    wire hardware_reset_state;
    integer bad_count = 0, checks_done = 0, seed = 39, i, t;
    prsc_pin_ctrl #(.STRETCH_CYC(N), .BLINK_BITS(3)) i_dut (.*);
    prsc_mac_model i_mac (.*);
    initial forever #2 clock = ~clock;
    always @(negedge clock)
        {core_tx_clk, core_rx_clk} <= {~core_tx_clk, core_tx_clk};
    task cyc(input integer n); repeat (n) @(negedge clock); endtask
    task check(input logic [4:0] seen, input logic [4:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Oldest noted strap set is due at each end of stretch
    always @(negedge clock) begin
        if (was === 1'b1 && internal_reset_ff === 1'b0)
            check({phy_addr_ff, cfg_strap_ff}, q.pop_front());
        was <= internal_reset_ff;
    end
    initial begin
        cyc(10);
        rst = 0;
        for (i = 0; i < 4; i++) begin
            s = $random(seed);
            {phy_addr_strap1, phy_addr_strap0, indicator_strap_in} = s;
            sw_reset = i[0];
            reset_n = i[0];
            cyc(3);
            q.push_back(s);
            if (i == 2) begin
                reset_n = 1;
                cyc(4);
                sw_reset = 1;
                cyc(2);
            end
            sw_reset = 0;
            reset_n = 1;
            for (t = 0; t < 40 && internal_reset_ff !== 1'b0; t++) cyc(1);
            check(t, N + 1);
            if (t == 40) conclude;
        end
        for (i = 0; i < 4; i++) begin
            {mii_float_mode, soft_power_down} = i;
            {core_rx_dv, core_rxd} = $random(seed);
            cyc(2);
            check(rxd_seen, i ? 4'h0 : core_rxd);
            check(mii_out_oe_ff, !i[1]);
        end
        for (i = 0; i < 3; i++) begin
            led_select = {3{i[1:0]}};
            led_status = $random(seed);
            cyc(3);
            check(indicator_out_ff, i == 0 ? 0 : i == 1 ? 7 : led_status);
            check(indicator_oe_ff, 7);
        end
        // Blink select: half of any eight cycles lit with a 3-bit divider
        led_select = 6'h3f;
        led_status = 3'h7;
        cyc(2);
        t = 0;
        repeat (8) begin
            cyc(1);
            t += indicator_out_ff[0];
        end
        check(t, 4);
        // Mid-run reset, then a fresh stretch and strap capture
        rst = 1;
        cyc(2);
        check({internal_reset_ff, cfg_valid_ff, indicator_oe_ff}, 5'h10);
        q.push_back(s);
        rst = 0;
        for (t = 0; t < 40 && internal_reset_ff !== 1'b0; t++) cyc(1);
        check(t, N + 1);
        cyc(1);
        conclude;
    end
endmodule // phy_reset_and_pin_state_control_bench
`default_nettype wire
